// File: include/coe_map.vh
// Constants for the clear-ops execute unit: encodings, fields, reset values, registers
`ifndef COE_MAP_VH
`define COE_MAP_VH

// ************************************************************
// Instruction encodings
// ************************************************************
`define COE_OP_CLRREG_HI    7'h03
`define COE_OP_CLRACC_HI    7'h02
`define COE_OP_WDRESTART    14'h0064
`define COE_OP_HI_MSB       13
`define COE_OP_HI_LSB       7
`define COE_ADDR_MSB        6
`define COE_ADDR_LSB        0

// ************************************************************
// Quarter phases
// ************************************************************
`define COE_Q1              2'h0
`define COE_Q2              2'h1
`define COE_Q3              2'h2
`define COE_Q4              2'h3

// ************************************************************
// Wishbone register offsets and fields
// ************************************************************
`define COE_REG_INSTR       4'h0
`define COE_REG_STATUS      4'h4
`define COE_REG_ACC         4'h8
`define COE_REG_WDOG        4'hc
`define COE_ST_ZERO         0
`define COE_ST_TIMEOUT_N    1
`define COE_ST_POWERDOWN_N  2
`define COE_ST_BUSY         3
`define COE_RST_ACC         8'h00
`define COE_RST_WDOG        8'h00

`endif

// File: hdl/coe_decode.v
// Instruction decoder for the three clearing operations
`timescale 1ns/1ns
`include "coe_map.vh"

module coe_decode (
  input  wire [13:0] instr,
  output wire        clear_register_op,
  output wire        clear_accumulator_op,
  output wire        watchdog_restart_op,
  output wire [6:0]  reg_addr
);

  // ************************************************************
  // Opcode matching
  // ************************************************************
  assign clear_register_op    = (instr[`COE_OP_HI_MSB:`COE_OP_HI_LSB] == `COE_OP_CLRREG_HI);
  assign clear_accumulator_op = (instr[`COE_OP_HI_MSB:`COE_OP_HI_LSB] == `COE_OP_CLRACC_HI);
  assign watchdog_restart_op  = (instr == `COE_OP_WDRESTART);
  assign reg_addr             = instr[`COE_ADDR_MSB:`COE_ADDR_LSB];

endmodule // coe_decode

// File: hdl/coe_execute.v
// Execute unit for clear-register, clear-accumulator and watchdog-restart instructions
//
// Notes on behaviour
// - Clear-register writes zero to the addressed register (address 0..127) and sets zero flag.
// - Clear-accumulator matches upper bits 00 0001 0, ignores low seven, zeroes accumulator, sets zero.
// - Clear-accumulator reads no register in Q2 and writes the accumulator in Q4.
// - Watchdog restart matches the full word 00 0000 0110 0100 and takes one instruction cycle.
// - Watchdog restart zeroes counter and prescaler and sets timeout and powerdown flags to one.
// - Watchdog restart idles in Q2 and clears the watchdog counter in Q4.
//
// Interface overview
// Software issues one instruction word by a write to the instruction register.
// A word written while busy is high is dropped; the bus still acknowledges it.
// Status bit 3 shows busy, so software polls it before issuing the next word.
// Each instruction runs four clocks, one per quarter phase, Q1 to Q4.
// The operand register is fetched in Q2 and the result is stored in Q4.
// For clear-register only, the register file sees a one-clock read strobe and a one-clock write strobe.
// Fetched data is latched but unused, since the stored result is always zero.
// The watchdog prescaler advances on each tick; its wrap advances the counter.
// A counter wrap drops the active-low timeout flag until the next restart.
// A restart in Q4 wins over a tick in the same clock.
// Nothing inside this block clears the powerdown flag.
// Opcodes other than the three clearing ones run as four-phase no-operations.
//
// Register map
// 0x0 instruction word, bits 13:0
// 0x4 status: bit 0 zero, bit 1 timeout_n, bit 2 powerdown_n, bit 3 busy
// 0x8 accumulator, read only
// 0xc watchdog counter, read only
// Other offsets read as zero and ignore writes.
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "coe_map.vh"

module coe_execute #(
  parameter WDOG_W = 8,
  parameter PRE_W  = 8
) (
  input  wire              clk,
  input  wire              rst_b,
  input  wire [3:0]        wb_adr_i,
  input  wire [31:0]       wb_dat_i,
  output reg  [31:0]       wb_dat_o,
  input  wire              wb_we_i,
  input  wire [3:0]        wb_sel_i,
  input  wire              wb_stb_i,
  input  wire              wb_cyc_i,
  output reg               wb_ack_o,
  input  wire              wdog_tick,
  output reg               rf_rd_en,
  output reg               rf_wr_en,
  output reg  [6:0]        rf_addr,
  output reg  [7:0]        rf_wr_data,
  input  wire [7:0]        rf_rd_data,
  output reg  [7:0]        accumulator,
  output reg               zero_flag,
  output reg               timeout_flag_n,
  output reg               powerdown_flag_n,
  output reg  [WDOG_W-1:0] watchdog_counter,
  output reg  [PRE_W-1:0]  wdog_prescaler,
  output reg  [1:0]        qphase,
  output reg               busy
);

  reg  [13:0] instr;
  reg  [7:0]  read_latch;
  wire        op_clrreg;
  wire        op_clracc;
  wire        op_wdrst;
  wire        wr_hit;
  wire [6:0]  dec_addr;
  wire        sel_low;
  wire        instr_write;
  wire        in_q1;
  wire        in_q3;
  wire        in_q4;
  reg  [31:0] next_rd_data;

  // ************************************************************
  // Helper functions
  // ************************************************************
  // True while an instruction runs and the sequencer sits in the wanted quarter
  function coe_phase_is;
    input       running;
    input [1:0] now;
    input [1:0] want;
    begin
      coe_phase_is = running & (now == want);
    end
  endfunction

  // Quarter phase strobes of the running instruction
  assign in_q1 = coe_phase_is(busy, qphase, `COE_Q1);
  assign in_q3 = coe_phase_is(busy, qphase, `COE_Q3);
  assign in_q4 = coe_phase_is(busy, qphase, `COE_Q4);

  coe_decode i_coe_decode (
    .instr                (instr),
    .clear_register_op    (op_clrreg),
    .clear_accumulator_op (op_clracc),
    .watchdog_restart_op  (op_wdrst),
    .reg_addr             (dec_addr)
  );

  // ************************************************************
  // Wishbone slave, registered ack after one wait state
  // ************************************************************
  assign wr_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;

  // Both low byte lanes must be enabled to carry a whole 14-bit word
  assign sel_low     = wb_sel_i[0] & wb_sel_i[1];
  assign instr_write = wr_hit & (wb_adr_i == `COE_REG_INSTR) & sel_low;

  // Read data selected by address, registered together with the ack
  always @* begin
    next_rd_data = 32'h0000_0000;
    case (wb_adr_i)
      `COE_REG_INSTR: begin
        next_rd_data[13:0] = instr;
      end
      `COE_REG_STATUS: begin
        next_rd_data[`COE_ST_ZERO]        = zero_flag;
        next_rd_data[`COE_ST_TIMEOUT_N]   = timeout_flag_n;
        next_rd_data[`COE_ST_POWERDOWN_N] = powerdown_flag_n;
        next_rd_data[`COE_ST_BUSY]        = busy;
      end
      `COE_REG_ACC: begin
        next_rd_data[7:0] = accumulator;
      end
      `COE_REG_WDOG: begin
        next_rd_data[WDOG_W-1:0] = watchdog_counter;
      end
      default: begin
        next_rd_data = 32'h0000_0000;
      end
    endcase
  end

  // Ack one cycle after strobe, dropped the next cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      wb_dat_o <= next_rd_data;
    end
  end

  // ************************************************************
  // Instruction issue and quarter phase sequencing
  // ************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      instr  <= 14'h0000;
      busy   <= 1'b0;
      qphase <= `COE_Q1;
    end else if (busy) begin
      qphase <= qphase + 2'h1;
      if (qphase == `COE_Q4)
        busy <= 1'b0; // Four clocks per word
    end else if (instr_write) begin // Only taken while idle
      instr  <= wb_dat_i[13:0];
      busy   <= 1'b1;
      qphase <= `COE_Q1;
    end
  end

  // ************************************************************
  // Register file strobes: read in Q2, write in Q4
  // ************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rf_rd_en   <= 1'b0;
      rf_wr_en   <= 1'b0;
      rf_addr    <= 7'h00;
      rf_wr_data <= 8'h00;
      read_latch <= 8'h00;
    end else begin
      rf_rd_en <= op_clrreg & in_q1;
      rf_wr_en <= op_clrreg & in_q3;
      if (busy && op_clrreg)
        rf_addr <= dec_addr;
      rf_wr_data <= 8'h00;
      if (rf_rd_en)
        read_latch <= rf_rd_data;
    end
  end

  // ************************************************************
  // Accumulator and zero flag, updated in Q4
  // ************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      accumulator <= `COE_RST_ACC;
      zero_flag   <= 1'b0;
    end else if (in_q4) begin
      if (op_clracc) begin
        accumulator <= 8'h00;
        zero_flag   <= 1'b1;
      end else if (op_clrreg) begin
        zero_flag   <= 1'b1;
      end
    end
  end

  // ************************************************************
  // Watchdog counter, prescaler and status flags
  // ************************************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_counter <= {WDOG_W{1'b0}};
      wdog_prescaler   <= {PRE_W{1'b0}};
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else if (op_wdrst && in_q4) begin
      watchdog_counter <= {WDOG_W{1'b0}};
      wdog_prescaler   <= {PRE_W{1'b0}};
      timeout_flag_n   <= 1'b1;
      powerdown_flag_n <= 1'b1;
    end else if (wdog_tick) begin
      wdog_prescaler <= wdog_prescaler + {{(PRE_W-1){1'b0}}, 1'b1};
      if (&wdog_prescaler) begin
        watchdog_counter <= watchdog_counter + {{(WDOG_W-1){1'b0}}, 1'b1};
        if (&watchdog_counter)
          timeout_flag_n <= 1'b0;
      end
    end
  end

endmodule // coe_execute

// File: verif/coe_execute_properties.sv
// Checker for the clear-ops execute unit
`timescale 1ns/1ns
module coe_execute_props #(parameter WDOG_W = 8, parameter PRE_W = 8) (
  input logic              clk,
  input logic              rst_b,
  input logic [3:0]        wb_adr_i,
  input logic [31:0]       wb_dat_i,
  input logic              wb_we_i,
  input logic [3:0]        wb_sel_i,
  input logic              wb_stb_i,
  input logic              wb_cyc_i,
  input logic              wb_ack_o,
  input logic              rf_rd_en,
  input logic              rf_wr_en,
  input logic [6:0]        rf_addr,
  input logic [7:0]        rf_wr_data,
  input logic [7:0]        accumulator,
  input logic              zero_flag,
  input logic              timeout_flag_n,
  input logic              powerdown_flag_n,
  input logic [WDOG_W-1:0] watchdog_counter,
  input logic [PRE_W-1:0]  wdog_prescaler,
  input logic [1:0]        qphase,
  input logic              busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Instruction accepted, and its decoded kind
  wire go = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i & (wb_adr_i == 4'h0)
            & (&wb_sel_i[1:0]) & ~busy;
  wire clr_reg = go & (wb_dat_i[13:7] == 7'h03);
  wire clr_acc = go & (wb_dat_i[13:7] == 7'h02);
  wire wd_rst  = go & (wb_dat_i[13:0] == 14'h0064);
  logic [6:0] adr_q;
  // Keeps the operand address of the last accepted instruction
  always @(posedge clk) if (go) adr_q <= wb_dat_i[6:0];
  sequence s_quiet; (!rf_rd_en && !rf_wr_en) [*4]; endsequence
  sequence s_wdog_clear;
    (watchdog_counter == 0 && wdog_prescaler == 0 && timeout_flag_n && powerdown_flag_n);
  endsequence
  sequence s_rd_wr;
    ##2 (rf_rd_en && qphase == 2'h1 && rf_addr == adr_q)
    ##2 (rf_wr_en && rf_wr_data == 8'h00 && rf_addr == adr_q);
  endsequence
  a_ack_one_pulse: assert property (go |-> ##1 wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse");
  a_clrreg_zero: assert property (clr_reg |-> ##5 zero_flag)
    else $error("clear register left zero flag low");
  a_clrreg_phases: assert property (clr_reg |-> s_rd_wr)
    else $error("clear register phases wrong");
  a_clracc_result: assert property (clr_acc |-> ##5 (accumulator == 8'h00 && zero_flag))
    else $error("clear accumulator result wrong");
  a_clracc_noread: assert property (clr_acc |-> ##1 s_quiet)
    else $error("clear accumulator touched registers");
  a_wdog_one_cycle: assert property (wd_rst |-> ##5 !busy)
    else $error("watchdog restart not one cycle");
  a_wdog_flags: assert property (wd_rst |-> ##5 s_wdog_clear)
    else $error("watchdog restart state wrong");
  a_wdog_idle_q2: assert property (wd_rst |-> ##1 s_quiet ##1 watchdog_counter == 0)
    else $error("watchdog restart phases wrong");
endmodule // coe_execute_props
bind coe_execute coe_execute_props #(.WDOG_W(WDOG_W), .PRE_W(PRE_W)) i_coe_execute_props (
  .clk(clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_ack_o(wb_ack_o),
  .rf_rd_en(rf_rd_en), .rf_wr_en(rf_wr_en), .rf_addr(rf_addr), .rf_wr_data(rf_wr_data),
  .accumulator(accumulator), .zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
  .powerdown_flag_n(powerdown_flag_n), .watchdog_counter(watchdog_counter),
  .wdog_prescaler(wdog_prescaler), .qphase(qphase), .busy(busy)
);

// File: verif/tb_coe_execute.sv
// Testbench for the clear-ops execute unit
`timescale 1ns/1ns
module tb_coe_execute;
  logic clk = 0, rst_b = 0, wb_we_i = 0, wb_stb_i = 0, wb_cyc_i = 0, wdog_tick = 0;
  logic wb_ack_o, rf_rd_en, rf_wr_en, zero_flag, timeout_flag_n, powerdown_flag_n, busy;
  logic [3:0]  wb_adr_i = 0, wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  logic [6:0]  rf_addr;
  logic [7:0]  rf_wr_data, rf_rd_data = 8'h5a, accumulator;
  logic [1:0]  watchdog_counter, wdog_prescaler, qphase;
  logic [3:0]  sel_v = 4'hf;
  logic [6:0]  wr_addr_seen = 7'h00;
  logic [7:0]  wr_data_seen = 8'hff;
  int bad_count = 0, tests_run = 0, rd_seen = 0, wr_seen = 0;
  coe_execute #(.WDOG_W(2), .PRE_W(2)) i_coe_execute (
    .clk(clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i),
    .wb_ack_o(wb_ack_o), .wdog_tick(wdog_tick), .rf_rd_en(rf_rd_en), .rf_wr_en(rf_wr_en),
    .rf_addr(rf_addr), .rf_wr_data(rf_wr_data), .rf_rd_data(rf_rd_data),
    .accumulator(accumulator), .zero_flag(zero_flag), .timeout_flag_n(timeout_flag_n),
    .powerdown_flag_n(powerdown_flag_n), .watchdog_counter(watchdog_counter),
    .wdog_prescaler(wdog_prescaler), .qphase(qphase), .busy(busy)
  );
  always #5 clk = ~clk;
  // Counts register file strobes and keeps what the last write carried
  always @(posedge clk) begin
    if (rf_rd_en)
      rd_seen <= rd_seen + 1;
    if (rf_wr_en) begin
      wr_seen      <= wr_seen + 1;
      wr_addr_seen <= rf_addr;
      wr_data_seen <= rf_wr_data;
    end
  end
  // One classic Wishbone cycle, held until ack
  task automatic wb(input [3:0] a, input [31:0] d, input w);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i, wb_we_i, wb_sel_i} <= {2'b11, a, d, w, sel_v};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Issue an instruction and poll until it retires
  task automatic exec(input [13:0] op);
    wb(4'h0, {18'h0, op}, 1);
    do wb(4'h4, 0, 0); while (q[3] !== 1'b0);
  endtask
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk) wdog_tick <= 1;
      @(posedge clk) wdog_tick <= 0;
    end
  endtask
  task automatic end_of_test;
    $display("tests_run %0d bad_count %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    end_of_test;
  end
  // Main sequence of tests
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1;
    wb(4'h4, 0, 0); chk("status", q, 32'h6);
    wb(4'h2, 0, 0); chk("unmapped", q, 32'h0);
    exec(14'h017f); chk("status", q, 32'h7);
    wb(4'h8, 0, 0); chk("acc", q, 32'h0);
    chk("rf reads", rd_seen, 32'h0);
    chk("rf writes", wr_seen, 32'h0);
    @(posedge clk) rst_b <= 0;
    @(posedge clk) rst_b <= 1;
    exec(14'h01ff); chk("status", q, 32'h7);
    chk("rf reads", rd_seen, 32'h1);
    chk("rf writes", wr_seen, 32'h1);
    chk("rf addr", wr_addr_seen, 32'h7f);
    chk("rf data", wr_data_seen, 32'h0);
    tick(22);
    wb(4'h4, 0, 0); chk("status", q, 32'h5);
    wb(4'hc, 0, 0); chk("wdog", q, 32'h1);
    chk("prescaler", wdog_prescaler, 32'h2);
    exec(14'h0065); chk("status", q, 32'h5);
    sel_v = 4'h1;
    exec(14'h0064); chk("status", q, 32'h5);
    sel_v = 4'hf;
    exec(14'h0064); chk("status", q, 32'h7);
    chk("prescaler", wdog_prescaler, 32'h0);
    wb(4'hc, 0, 0); chk("wdog", q, 32'h0);
    chk("rf writes", wr_seen, 32'h1);
    end_of_test;
  end
endmodule // tb_coe_execute
